// file: mf_eval_pkg.sv
package mf_eval_pkg;

  // Data widths
  localparam int DATA_W = 8;
  localparam int PROD_W = 16;
  localparam int PTR_W  = 16;

  // Full-scale grade and the slope code that means a vertical side
  localparam logic [7:0]  FULL_SCALE    = 8'hFF;
  localparam logic [7:0]  SLOPE_VERTICAL = 8'h00;
  localparam logic [7:0]  GRADE_ZERO    = 8'h00;

  // Pointer advance after the store
  localparam logic [15:0] MF_PTR_STEP  = 16'h0004;
  localparam logic [15:0] FUZ_PTR_STEP = 16'h0001;

  // Reset values
  localparam logic [15:0] PTR_RESET = 16'h0000;

  // One membership definition as fetched by the load path
  typedef struct packed {
    logic [7:0] point1;
    logic [7:0] point2;
    logic [7:0] slope1;
    logic [7:0] slope2;
  } mf_def_t;

  // Grade store request towards the store path
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } grade_store_t;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_LOAD   = 6'b000010,
    ST_DELTA  = 6'b000100,
    ST_GRADE  = 6'b001000,
    ST_SELECT = 6'b010000,
    ST_STORE  = 6'b100000
  } mf_state_t;

  // True when a wide grade lies above full scale
  function automatic logic overFull(input logic [15:0] g);
    overFull = (g > {8'h00, FULL_SCALE});
  endfunction : overFull

endpackage : mf_eval_pkg

// file: mf_edge_unit.sv
`timescale 1ns/1ps
`default_nettype none
// One side of the trapezoid: delta with borrow, then delta times slope
module mf_edge_unit
  import mf_eval_pkg::*;
(
  input  wire logic [7:0]  minuend,    // Left operand of the subtraction
  input  wire logic [7:0]  subtrahend, // Right operand of the subtraction
  input  wire logic [7:0]  deltaIn,    // Registered delta for the product
  input  wire logic [7:0]  slope,      // Slope of this side
  output logic      [7:0]  delta,      // Difference, low eight bits
  output logic             negative,   // Borrow out, delta below zero
  output logic      [15:0] product     // Full-width grade
);

  wire logic [8:0] diffWide;

  // Nine-bit subtraction keeps the borrow
  assign diffWide = {1'b0, minuend} - {1'b0, subtrahend};
  assign delta    = diffWide[7:0];
  assign negative = diffWide[8];
  // Sixteen bits hold any product, so exceeding full scale is visible
  assign product  = {8'h00, deltaIn} * {8'h00, slope};

endmodule : mf_edge_unit
`default_nettype wire

// file: mf_eval.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - A slope of zero means a vertical side, not a flat edge.
// - The second cycle forms both eight-bit deltas and sets the outside flag from them.
// - The outside flag is clear inside the trapezoid and set when either delta is negative.
// - With the outside flag set, both tentative grades are forced to zero in the third cycle.
// - Step one picks full scale when the right slope is zero or the right grade is over full scale and the flag is clear, else the right grade.
// - Step two keeps that grade when the left slope is zero or the left grade is over full scale, else takes the left grade.
// - The result is zero below the left or above the right breakpoint, and for all inputs when the breakpoints are reversed.
// - After the grade is stored the definition pointer advances by four and the fuzzy input pointer by one.
module mf_eval
  import mf_eval_pkg::*;
(
  input  wire logic          sys_clk,     // Processor clock
  input  wire logic          rst_n,       // Asynchronous reset, active low
  input  wire logic          clkEn,       // Clock enable, freezes all state when low
  input  wire logic          start,       // One-cycle request to evaluate
  input  wire logic [7:0]    inputVal,    // System input from the accumulator
  input  wire logic [15:0]   mfPtrIn,     // Definition pointer at start
  input  wire logic [15:0]   fuzPtrIn,    // Fuzzy input pointer at start
  input  wire mf_def_t       mfDef,       // Definition from the load path
  output logic               busy,        // Evaluation in progress
  output logic               storeValid,  // One-cycle grade store request
  output grade_store_t       store,       // Store address and grade
  output logic               done,        // One-cycle completion pulse
  output logic [15:0]        mfPtrOut,    // Advanced definition pointer
  output logic [15:0]        fuzPtrOut,   // Advanced fuzzy input pointer
  output logic               outsideFlag  // Outside-trapezoid flag
);

  mf_state_t    state_q, state_d;
  logic [7:0]   in_q;
  mf_def_t      def_q;
  logic [7:0]   delta1_q, delta2_q;
  logic         outside_q;
  logic [15:0]  grade1_q, grade2_q;
  logic [7:0]   grade_q;
  logic [15:0]  mfPtr_q, fuzPtr_q;
  logic         storeValid_q, done_q;
  logic         busy_q;
  grade_store_t store_q;

  wire logic [7:0]  delta1, delta2;
  wire logic        neg1, neg2;
  wire logic [15:0] prod1, prod2;
  wire logic        takeFull, keepGrade;
  wire logic [7:0]  stepOne, stepTwo;
  wire logic        accept;
  wire logic        inLoad, inDelta, inGrade, inSelect, inStore;
  wire logic        busyNext;

  // Left edge: input minus point1, product from registered delta
  mf_edge_unit leftEdge (
    .minuend    (in_q),
    .subtrahend (def_q.point1),
    .deltaIn    (delta1_q),
    .slope      (def_q.slope1),
    .delta      (delta1),
    .negative   (neg1),
    .product    (prod1)
  );

  // Right edge: point2 minus input
  mf_edge_unit rightEdge (
    .minuend    (def_q.point2),
    .subtrahend (in_q),
    .deltaIn    (delta2_q),
    .slope      (def_q.slope2),
    .delta      (delta2),
    .negative   (neg2),
    .product    (prod2)
  );

  // Two-step grade selection
  assign takeFull  = ((def_q.slope2 == SLOPE_VERTICAL) || overFull(grade2_q)) && !outside_q;
  assign stepOne   = takeFull ? FULL_SCALE : grade2_q[7:0];
  assign keepGrade = (def_q.slope1 == SLOPE_VERTICAL) || overFull(grade1_q);
  assign stepTwo   = keepGrade ? stepOne : grade1_q[7:0];

  // State decode shared by the datapath registers
  assign accept   = clkEn && (state_q == ST_IDLE) && start;
  assign inLoad   = (state_q == ST_LOAD);
  assign inDelta  = (state_q == ST_DELTA);
  assign inGrade  = (state_q == ST_GRADE);
  assign inSelect = (state_q == ST_SELECT);
  assign inStore  = (state_q == ST_STORE);
  assign busyNext = (state_d != ST_IDLE);

  // Next-state decode
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:   if (start) state_d = ST_LOAD;
      ST_LOAD:   state_d = ST_DELTA;
      ST_DELTA:  state_d = ST_GRADE;
      ST_GRADE:  state_d = ST_SELECT;
      ST_SELECT: state_d = ST_STORE;
      ST_STORE:  state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  // Sequencer
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
    end
    else if (clkEn)
    begin
      state_q <= state_d;
      busy_q  <= busyNext;
    end
  end

  // Operand capture at the start request
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_q  <= GRADE_ZERO;
      def_q <= '0;
    end
    else if (accept)
    begin
      in_q  <= inputVal;
      def_q <= mfDef;
    end
  end

  // Cycle two: deltas and outside flag
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      delta1_q  <= GRADE_ZERO;
      delta2_q  <= GRADE_ZERO;
      outside_q <= 1'b0;
    end
    else if (clkEn && inLoad)
    begin
      delta1_q  <= delta1;
      delta2_q  <= delta2;
      outside_q <= neg1 | neg2;
    end
  end

  // Cycle three: wide grades, zero outside the trapezoid
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      grade1_q <= '0;
      grade2_q <= '0;
    end
    else if (clkEn && inDelta)
    begin
      grade1_q <= outside_q ? 16'h0000 : prod1;
      grade2_q <= outside_q ? 16'h0000 : prod2;
    end
  end

  // Cycle four: final grade
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      grade_q <= GRADE_ZERO;
    else if (clkEn && inGrade)
      grade_q <= stepTwo;
  end

  // Store request and completion pulse
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      storeValid_q <= 1'b0;
      done_q       <= 1'b0;
      store_q      <= '0;
    end
    else if (clkEn)
    begin
      storeValid_q <= inSelect;
      done_q       <= inStore;
      if (inSelect)
      begin
        store_q.addr <= fuzPtr_q;
        store_q.data <= grade_q;
      end
    end
  end

  // Pointers: taken with the request, stepped once the grade is stored
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mfPtr_q  <= PTR_RESET;
      fuzPtr_q <= PTR_RESET;
    end
    else if (accept)
    begin
      mfPtr_q  <= mfPtrIn;
      fuzPtr_q <= fuzPtrIn;
    end
    else if (clkEn && inStore)
    begin
      mfPtr_q  <= mfPtr_q + MF_PTR_STEP;
      fuzPtr_q <= fuzPtr_q + FUZ_PTR_STEP;
    end
  end

  // Outputs straight from flops
  assign busy        = busy_q;
  assign storeValid  = storeValid_q;
  assign store       = store_q;
  assign done        = done_q;
  assign mfPtrOut    = mfPtr_q;
  assign fuzPtrOut   = fuzPtr_q;
  assign outsideFlag = outside_q;

endmodule : mf_eval
`default_nettype wire

// file: mf_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Store side of the memory bus: keeps the last grade, counts writes
module mf_mem_model
  import mf_eval_pkg::*;
(
  input  wire logic         sys_clk,    // Clock
  input  wire grade_store_t store,      // Address and grade
  input  wire logic         storeValid, // Write strobe
  output var  int           writes,     // Write count
  output var  logic [7:0]   lastGrade   // Grade of the latest write
);
  initial writes = 0;
  initial lastGrade = 8'h00;
  // One write per strobe
  always @(posedge sys_clk)
  begin
    if (storeValid)
    begin
      lastGrade <= store.data;
      writes <= writes + 1;
    end
  end
endmodule : mf_mem_model
`default_nettype wire

// file: mf_eval_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Timing and grade checks on the evaluator ports
module mf_eval_properties
  import mf_eval_pkg::*;
(
  input wire logic         sys_clk,     // Clock
  input wire logic         rst_n,       // Reset
  input wire logic         clkEn,       // Enable
  input wire logic         start,       // Request
  input wire logic [7:0]   inputVal,    // Input
  input wire logic [15:0]  mfPtrIn,     // Pointer
  input wire logic [15:0]  fuzPtrIn,    // Pointer
  input wire mf_def_t      mfDef,       // Definition
  input wire logic         busy,        // Busy
  input wire logic         storeValid,  // Store
  input wire grade_store_t store,       // Store data
  input wire logic         done,        // Done
  input wire logic [15:0]  mfPtrOut,    // Pointer
  input wire logic [15:0]  fuzPtrOut,   // Pointer
  input wire logic         outsideFlag  // Flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0]  inQ;
  mf_def_t     defQ;
  logic [15:0] mfQ, fuzQ;
  wire take = start && !busy && clkEn;
  // Operands of the accepted request
  always_ff @(posedge sys_clk)
  begin
    if (take)
    begin
      inQ  <= inputVal;
      defQ <= mfDef;
      mfQ  <= mfPtrIn;
      fuzQ <= fuzPtrIn;
    end
  end
  // Reference grade
  wire [8:0] d1 = {1'b0, inQ} - {1'b0, defQ.point1};
  wire [8:0] d2 = {1'b0, defQ.point2} - {1'b0, inQ};
  wire out = d1[8] | d2[8];
  wire [15:0] g1 = out ? 16'h0000 : d1[7:0] * defQ.slope1;
  wire [15:0] g2 = out ? 16'h0000 : d2[7:0] * defQ.slope2;
  wire [7:0] s1g = ((defQ.slope2 == 8'h00 || g2 > 16'h00FF) && !out) ? 8'hFF : g2[7:0];
  wire [7:0] expG = (defQ.slope1 == 8'h00 || g1 > 16'h00FF) ? s1g : g1[7:0];
  sequence s_take; take; endsequence
  sequence s_finish; storeValid ##1 done; endsequence
  property p_latency; s_take |-> ##5 s_finish; endproperty
  property p_busy; s_take |=> busy [*5] ##1 !busy; endproperty
  property p_flag; done |-> outsideFlag == out; endproperty
  property p_zero; storeValid && outsideFlag |-> store.data == 8'h00; endproperty
  property p_grade; storeValid |-> store.data == expG; endproperty
  property p_vert; storeValid && !out && defQ.slope1 == 8'h00 && defQ.slope2 == 8'h00 |-> store.data == 8'hFF;
  endproperty
  property p_range; storeValid && (inQ < defQ.point1 || inQ > defQ.point2) |-> store.data == 8'h00; endproperty
  property p_ptr; done |-> mfPtrOut == mfQ + 16'h0004 && fuzPtrOut == fuzQ + 16'h0001 && $past(store.addr) == fuzQ;
  endproperty
  a_latency: assert property (p_latency) else $error("store or done off time");
  a_busy: assert property (p_busy) else $error("busy length wrong");
  a_flag: assert property (p_flag) else $error("outside flag wrong");
  a_zero: assert property (p_zero) else $error("outside grade not zero");
  a_grade: assert property (p_grade) else $error("grade wrong");
  a_vert: assert property (p_vert) else $error("vertical sides not full");
  a_range: assert property (p_range) else $error("grade outside range");
  a_ptr: assert property (p_ptr) else $error("pointer advance wrong");
endmodule : mf_eval_properties
bind mf_eval mf_eval_properties chk (.sys_clk, .rst_n, .clkEn, .start, .inputVal, .mfPtrIn, .fuzPtrIn, .mfDef,
  .busy, .storeValid, .store, .done, .mfPtrOut, .fuzPtrOut, .outsideFlag);
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin errors++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb
  import mf_eval_pkg::*;
;
  logic sys_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, start = 1'b0, busy, storeValid, done, outsideFlag;
  logic [7:0] inputVal = 8'h00;
  logic [7:0] lastGrade;
  logic [15:0] mfPtrIn = 16'h0000, fuzPtrIn = 16'h0000, mfPtrOut, fuzPtrOut;
  mf_def_t mfDef = '0;
  grade_store_t store;
  int writes, errors = 0, compares = 0;
  mf_eval dut (.sys_clk, .rst_n, .clkEn, .start, .inputVal, .mfPtrIn, .fuzPtrIn, .mfDef,
    .busy, .storeValid, .store, .done, .mfPtrOut, .fuzPtrOut, .outsideFlag);
  mf_mem_model mem (.sys_clk, .store, .storeValid, .writes, .lastGrade);
  always #20 sys_clk = ~sys_clk;
  // Closing report
  task print_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  // One evaluation; hold keeps start up while busy, with a changed pointer
  task automatic eval(input logic [7:0] v, input mf_def_t d, input logic [7:0] g, input logic f, input bit hold);
    int n;
    int w;
    logic [15:0] a;
    w = writes;
    a = {d.point1, v};
    @(posedge sys_clk);
    inputVal <= v;
    mfDef <= d;
    mfPtrIn <= {8'h00, v};
    fuzPtrIn <= a;
    start <= 1'b1;
    @(posedge sys_clk);
    if (hold)
    begin
      fuzPtrIn <= ~a;
      inputVal <= ~v;
      repeat (2) @(posedge sys_clk);
    end
    fuzPtrIn <= ~a;
    start <= 1'b0;
    n = 0;
    #1;
    while (storeValid !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (storeValid !== 1'b1)
    begin
      errors++;
      print_verdict();
    end
    else
    begin
      `CHK("grade", g, store.data)
      `CHK("addr", a, store.addr)
      @(posedge sys_clk);
      #1;
      `CHK("done", 1'b1, done)
      `CHK("outside", f, outsideFlag)
      `CHK("mf ptr", {8'h00, v} + 16'h0004, mfPtrOut)
      `CHK("fuz ptr", a + 16'h0001, fuzPtrOut)
      `CHK("writes", w + 1, writes)
      `CHK("stored", g, lastGrade)
    end
  endtask : eval
  // Sloped sides that meet far above full scale
  task t_slopes;
    eval(8'h30, 32'h20E00404, 8'h40, 1'b0, 0);
    eval(8'h80, 32'h20E00404, 8'hFF, 1'b0, 0);
    eval(8'hD0, 32'h20E00404, 8'h40, 1'b0, 0);
  endtask : t_slopes
  // Crisp sides, edges and just outside
  task t_vertical;
    eval(8'h40, 32'h40800000, 8'hFF, 1'b0, 0);
    eval(8'h80, 32'h40800000, 8'hFF, 1'b0, 0);
    eval(8'h3F, 32'h40800000, 8'h00, 1'b1, 0);
    eval(8'h81, 32'h40800000, 8'h00, 1'b1, 0);
  endtask : t_vertical
  // Reversed breakpoints, crossed sides, outside with one crisp side
  task t_abnormal;
    eval(8'h60, 32'h80400000, 8'h00, 1'b1, 0);
    eval(8'h50, 32'h40800202, 8'h20, 1'b0, 0);
    eval(8'h50, 32'h40800002, 8'h60, 1'b0, 0);
    eval(8'h50, 32'h40800200, 8'h20, 1'b0, 0);
    eval(8'h90, 32'h40800200, 8'h00, 1'b1, 0);
    eval(8'h30, 32'h40800002, 8'h00, 1'b1, 1);
  endtask : t_abnormal
  // A request with the clock enable low must change nothing
  task t_enable;
    logic [15:0] p;
    p = mfPtrOut;
    @(posedge sys_clk);
    clkEn <= 1'b0;
    start <= 1'b1;
    mfPtrIn <= ~p;
    repeat (3) @(posedge sys_clk);
    clkEn <= 1'b1;
    start <= 1'b0;
    #1;
    `CHK("frozen busy", 1'b0, busy)
    `CHK("frozen ptr", p, mfPtrOut)
  endtask : t_enable
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_slopes();
    t_vertical();
    t_abnormal();
    t_enable();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
